// file: logic/fe_cal_regs.sv
/*
 * Front-end trim and synthesizer calibration register set, AHB-Lite slave.
 * Assumes: one 40 MHz clock, calibration sequencer and analog trims
 * outside; wake strobes come from power control on the same clock.
 */
// Operation
// - receive trim holds four r/w 2-bit bias fields, reset 01,01,01,10.
// - transmit lo buffer bias at 5:4 is r/w reset 01; 7:6 and 3 read-only.
// - pump calibration stage is skipped while its enable field 5:4 is 0.
// - pump result 3:0 holds the calibration result setting pump current.
// - pump register returns to reset on wake from either deepest sleep.
// - vco bit 5 selects the core, 0 low 1 high, reset 0.
// - vco result 4:0 reports current calibration, writable, reset 01010.
// - results read back and rewritten replace a fresh calibration.
module fe_cal_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic wake_deep_sleep_a,
    input wire logic wake_deep_sleep_b,
    input wire logic cal_pump_valid,
    input wire logic [3:0] cal_pump_result,
    input wire logic cal_vco_valid,
    input wire logic [4:0] cal_vco_result,
    output logic [1:0] low_noise_amp_bias,
    output logic [1:0] amp_to_mixer_bias,
    output logic [1:0] rx_lo_buffer_bias,
    output logic [1:0] mixer_bias,
    output logic [1:0] tx_lo_buffer_bias,
    output logic [2:0] tx_reserved,
    output logic [1:0] pump_cal_config,
    output logic pump_cal_stage_run,
    output logic [3:0] pump_current,
    output logic osc_core_select,
    output logic [4:0] osc_current
);

    logic wr_pend_q;
    logic [fe_cal_pkg::ADDR_W-1:0] wr_addr_q;
    logic addr_ok;
    logic wake_sync_a1_q;
    logic wake_sync_a2_q;
    logic wake_sync_b1_q;
    logic wake_sync_b2_q;
    logic wake_rst;
    logic we_rx;
    logic we_tx;
    logic we_pump;
    logic we_vco;
    logic [7:0] wd;
    logic [31:0] rd_d;
    logic [1:0] lna_v;
    logic [1:0] amix_v;
    logic [1:0] rxlo_v;
    logic [1:0] mix_v;
    logic [1:0] txlo_v;
    logic [2:0] rsvd_v;
    logic [1:0] pcfg_v;
    logic [1:0] pen_v;
    logic [3:0] pres_v;
    logic [0:0] core_v;
    logic [4:0] vres_v;

    assign addr_ok = haddr[31:fe_cal_pkg::ADDR_W] == '0;

    // wake strobes may come from an always-on domain: two flops each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_sync_a1_q <= 1'b0;
            wake_sync_a2_q <= 1'b0;
            wake_sync_b1_q <= 1'b0;
            wake_sync_b2_q <= 1'b0;
        end else begin
            wake_sync_a1_q <= wake_deep_sleep_a;
            wake_sync_a2_q <= wake_sync_a1_q;
            wake_sync_b1_q <= wake_deep_sleep_b;
            wake_sync_b2_q <= wake_sync_b1_q;
        end
    end

    assign wake_rst = wake_sync_a2_q | wake_sync_b2_q;

    // address phase capture; writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans == fe_cal_pkg::HTRANS_NONSEQ
                && hwrite && addr_ok;
            wr_addr_q <= haddr[fe_cal_pkg::ADDR_W-1:0];
        end
    end

    assign wd = hwdata[7:0];
    assign we_rx = wr_pend_q && wr_addr_q == fe_cal_pkg::ADDR_RX_TRIM;
    assign we_tx = wr_pend_q && wr_addr_q == fe_cal_pkg::ADDR_TX_TRIM;
    assign we_pump = wr_pend_q && wr_addr_q == fe_cal_pkg::ADDR_CAL_PUMP;
    assign we_vco = wr_pend_q && wr_addr_q == fe_cal_pkg::ADDR_CAL_VCO;

    fe_cal_field #(.W(2), .RST(fe_cal_pkg::RST_LNA_BIAS)) u_lna (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(1'b0),
        .sw_we(we_rx),
        .sw_data(wd[fe_cal_pkg::LNA_BIAS_LSB+:2]),
        .hw_we(1'b0),
        .hw_data(2'h0),
        .value(lna_v)
    );
    fe_cal_field #(.W(2), .RST(fe_cal_pkg::RST_AMP_MIX_BIAS)) u_amix (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(1'b0),
        .sw_we(we_rx),
        .sw_data(wd[fe_cal_pkg::AMP_MIX_LSB+:2]),
        .hw_we(1'b0),
        .hw_data(2'h0),
        .value(amix_v)
    );
    fe_cal_field #(.W(2), .RST(fe_cal_pkg::RST_RX_LO_BIAS)) u_rxlo (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(1'b0),
        .sw_we(we_rx),
        .sw_data(wd[fe_cal_pkg::RX_LO_LSB+:2]),
        .hw_we(1'b0),
        .hw_data(2'h0),
        .value(rxlo_v)
    );
    fe_cal_field #(.W(2), .RST(fe_cal_pkg::RST_MIXER_BIAS)) u_mix (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(1'b0),
        .sw_we(we_rx),
        .sw_data(wd[fe_cal_pkg::MIXER_LSB+:2]),
        .hw_we(1'b0),
        .hw_data(2'h0),
        .value(mix_v)
    );

    fe_cal_field #(.W(2), .RST(fe_cal_pkg::RST_TX_LO_BIAS)) u_txlo (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(1'b0),
        .sw_we(we_tx),
        .sw_data(wd[fe_cal_pkg::TX_LO_LSB+:2]),
        .hw_we(1'b0),
        .hw_data(2'h0),
        .value(txlo_v)
    );
    // reserved field stored as written; software keeps it 000
    fe_cal_field #(.W(3), .RST(fe_cal_pkg::RST_TX_RSVD)) u_rsvd (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(1'b0),
        .sw_we(we_tx),
        .sw_data(wd[fe_cal_pkg::TX_RSVD_LSB+:3]),
        .hw_we(1'b0),
        .hw_data(3'h0),
        .value(rsvd_v)
    );

    fe_cal_field #(.W(2), .RST(fe_cal_pkg::RST_PUMP_CFG)) u_pcfg (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(wake_rst),
        .sw_we(we_pump),
        .sw_data(wd[fe_cal_pkg::PUMP_CFG_LSB+:2]),
        .hw_we(1'b0),
        .hw_data(2'h0),
        .value(pcfg_v)
    );
    fe_cal_field #(.W(2), .RST(fe_cal_pkg::RST_PUMP_EN)) u_pen (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(wake_rst),
        .sw_we(we_pump),
        .sw_data(wd[fe_cal_pkg::PUMP_EN_LSB+:2]),
        .hw_we(1'b0),
        .hw_data(2'h0),
        .value(pen_v)
    );
    // result: engine loads it, software may restore it
    fe_cal_field #(.W(4), .RST(fe_cal_pkg::RST_PUMP_RES)) u_pres (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(wake_rst),
        .sw_we(we_pump),
        .sw_data(wd[fe_cal_pkg::PUMP_RES_LSB+:4]),
        .hw_we(cal_pump_valid),
        .hw_data(cal_pump_result),
        .value(pres_v)
    );

    fe_cal_field #(.W(1), .RST(fe_cal_pkg::RST_CORE_SEL)) u_core (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(1'b0),
        .sw_we(we_vco),
        .sw_data(wd[fe_cal_pkg::CORE_SEL_BIT+:1]),
        .hw_we(1'b0),
        .hw_data(1'b0),
        .value(core_v)
    );
    fe_cal_field #(.W(5), .RST(fe_cal_pkg::RST_VCO_RES)) u_vres (
        .hclk(hclk),
        .hresetn(hresetn),
        .wake_reset(1'b0),
        .sw_we(we_vco),
        .sw_data(wd[fe_cal_pkg::VCO_RES_LSB+:5]),
        .hw_we(cal_vco_valid),
        .hw_data(cal_vco_result),
        .value(vres_v)
    );

    // read mux; unused bits and upper bits read zero
    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (haddr[fe_cal_pkg::ADDR_W-1:0])
            fe_cal_pkg::ADDR_RX_TRIM: begin
                rd_d[7:0] = {lna_v, amix_v, rxlo_v, mix_v};
            end
            fe_cal_pkg::ADDR_TX_TRIM: begin
                rd_d[fe_cal_pkg::TX_LO_LSB+:2] = txlo_v;
                rd_d[fe_cal_pkg::TX_RSVD_LSB+:3] = rsvd_v;
            end
            fe_cal_pkg::ADDR_CAL_PUMP: begin
                rd_d[7:0] = {pcfg_v, pen_v, pres_v};
            end
            fe_cal_pkg::ADDR_CAL_VCO: begin
                rd_d[fe_cal_pkg::CORE_SEL_BIT] = core_v[0];
                rd_d[fe_cal_pkg::VCO_RES_LSB+:5] = vres_v;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
        if (!addr_ok) begin
            rd_d = 32'h0000_0000;
        end
    end

    // zero-wait slave: read data registered for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans == fe_cal_pkg::HTRANS_NONSEQ
                && !hwrite) begin
            hrdata <= rd_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= fe_cal_pkg::HRESP_OKAY[0];
        end
    end

    // registered copies toward the analog side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_noise_amp_bias <= fe_cal_pkg::RST_LNA_BIAS;
            amp_to_mixer_bias <= fe_cal_pkg::RST_AMP_MIX_BIAS;
            rx_lo_buffer_bias <= fe_cal_pkg::RST_RX_LO_BIAS;
            mixer_bias <= fe_cal_pkg::RST_MIXER_BIAS;
            tx_lo_buffer_bias <= fe_cal_pkg::RST_TX_LO_BIAS;
            tx_reserved <= fe_cal_pkg::RST_TX_RSVD;
            pump_cal_config <= fe_cal_pkg::RST_PUMP_CFG;
            pump_cal_stage_run <= 1'b1;
            pump_current <= fe_cal_pkg::RST_PUMP_RES;
            osc_core_select <= fe_cal_pkg::RST_CORE_SEL;
            osc_current <= fe_cal_pkg::RST_VCO_RES;
        end else begin
            low_noise_amp_bias <= lna_v;
            amp_to_mixer_bias <= amix_v;
            rx_lo_buffer_bias <= rxlo_v;
            mixer_bias <= mix_v;
            tx_lo_buffer_bias <= txlo_v;
            tx_reserved <= rsvd_v;
            pump_cal_config <= pcfg_v;
            // stage skipped when enable is zero
            pump_cal_stage_run <= pen_v != 2'h0;
            pump_current <= pres_v;
            osc_core_select <= core_v[0];
            osc_current <= vres_v;
        end
    end

endmodule : fe_cal_regs

// file: logic/fe_cal_pkg.sv
/*
 * Register map, field layout and reset values for the radio front-end
 * trim and synthesizer calibration register set.
 * Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
 */
package fe_cal_pkg;

    // printed offsets are not word multiples: they are register indices
    localparam logic [15:0] IDX_RX_TRIM = 16'hDF1A;
    localparam logic [15:0] IDX_TX_TRIM = 16'hDF1B;
    localparam logic [15:0] IDX_CAL_PUMP = 16'hDF1C;
    localparam logic [15:0] IDX_CAL_VCO = 16'hDF1D;
    localparam int ADDR_W = 18;
    localparam logic [ADDR_W-1:0] ADDR_RX_TRIM = {IDX_RX_TRIM, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_TX_TRIM = {IDX_TX_TRIM, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CAL_PUMP = {IDX_CAL_PUMP, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CAL_VCO = {IDX_CAL_VCO, 2'h0};

    // receive trim fields
    localparam logic [1:0] RST_LNA_BIAS = 2'h1;
    localparam logic [1:0] RST_AMP_MIX_BIAS = 2'h1;
    localparam logic [1:0] RST_RX_LO_BIAS = 2'h1;
    localparam logic [1:0] RST_MIXER_BIAS = 2'h2;
    localparam int LNA_BIAS_LSB = 6;
    localparam int AMP_MIX_LSB = 4;
    localparam int RX_LO_LSB = 2;
    localparam int MIXER_LSB = 0;

    // transmit trim fields
    localparam int TX_LO_LSB = 4;
    localparam logic [1:0] RST_TX_LO_BIAS = 2'h1;
    localparam int TX_RSVD_LSB = 0;
    localparam logic [2:0] RST_TX_RSVD = 3'h0;

    // charge pump calibration fields
    localparam int PUMP_CFG_LSB = 6;
    localparam logic [1:0] RST_PUMP_CFG = 2'h2;
    localparam int PUMP_EN_LSB = 4;
    localparam logic [1:0] RST_PUMP_EN = 2'h2;
    localparam int PUMP_RES_LSB = 0;
    localparam logic [3:0] RST_PUMP_RES = 4'h0;

    // vco calibration fields
    localparam int CORE_SEL_BIT = 5;
    localparam logic RST_CORE_SEL = 1'b0;
    localparam int VCO_RES_LSB = 0;
    localparam logic [4:0] RST_VCO_RES = 5'h0A;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage : fe_cal_pkg

// file: logic/fe_cal_field.sv
/*
 * One register field: software write, calibration-engine load and
 * return to reset value on a deep-sleep wake.
 * Assumes: a single clock and async active-low reset.
 */
module fe_cal_field #(
    parameter int W = 2,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wake_reset,
    input wire logic sw_we,
    input wire logic [W-1:0] sw_data,
    input wire logic hw_we,
    input wire logic [W-1:0] hw_data,
    output logic [W-1:0] value
);

    // software write wins over an engine load in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value <= RST;
        end else if (wake_reset) begin
            value <= RST;
        end else if (sw_we) begin
            value <= sw_data;
        end else if (hw_we) begin
            value <= hw_data;
        end
    end

endmodule : fe_cal_field

// file: verif/fe_cal_regs_asserts.sv
/* checker: bus and field-output relations of the front-end register set.
   assumes hready tied to hreadyout, no load or wake during a write. */
module fe_cal_regs_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic wake_deep_sleep_a,
    input wire logic wake_deep_sleep_b,
    input wire logic cal_pump_valid,
    input wire logic [3:0] cal_pump_result,
    input wire logic cal_vco_valid,
    input wire logic [4:0] cal_vco_result,
    input wire logic [1:0] low_noise_amp_bias,
    input wire logic [1:0] amp_to_mixer_bias,
    input wire logic [1:0] rx_lo_buffer_bias,
    input wire logic [1:0] mixer_bias,
    input wire logic [1:0] tx_lo_buffer_bias,
    input wire logic [2:0] tx_reserved,
    input wire logic [1:0] pump_cal_config,
    input wire logic pump_cal_stage_run,
    input wire logic [3:0] pump_current,
    input wire logic osc_core_select,
    input wire logic [4:0] osc_current
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_q;
    logic [31:0] wa_q;
    wire logic take = hsel && hready && htrans == fe_cal_pkg::HTRANS_NONSEQ;
    wire logic w_rx = wr_q && wa_q == {14'h0, fe_cal_pkg::ADDR_RX_TRIM};
    wire logic w_tx = wr_q && wa_q == {14'h0, fe_cal_pkg::ADDR_TX_TRIM};
    wire logic w_pump = wr_q && wa_q == {14'h0, fe_cal_pkg::ADDR_CAL_PUMP};
    wire logic w_vco = wr_q && wa_q == {14'h0, fe_cal_pkg::ADDR_CAL_VCO};
    // data phase tracking, write lands at the following edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 32'h0;
        end else begin
            wr_q <= take && hwrite;
            wa_q <= haddr;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_ready_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or gave an error response");
    a_rx_write_fields: assert property (w_rx |-> ##2
        {low_noise_amp_bias, amp_to_mixer_bias, rx_lo_buffer_bias,
        mixer_bias} == $past(hwdata[7:0], 2))
        else $error("receive trim outputs do not follow write");
    a_tx_write_fields: assert property (w_tx |-> ##2
        tx_lo_buffer_bias == $past(hwdata[5:4], 2)
        && tx_reserved == $past(hwdata[2:0], 2))
        else $error("transmit trim outputs do not follow write");
    a_pump_write_fields: assert property (w_pump |-> ##2
        {pump_cal_config, pump_current}
        == {$past(hwdata[7:6], 2), $past(hwdata[3:0], 2)})
        else $error("pump outputs do not follow write");
    a_pump_stage_skip: assert property (w_pump |-> ##2
        pump_cal_stage_run == ($past(hwdata[5:4], 2) != 2'h0))
        else $error("pump stage run wrong for enable field");
    a_vco_write_fields: assert property (w_vco |-> ##2
        {osc_core_select, osc_current} == $past(hwdata[5:0], 2))
        else $error("vco outputs do not follow write");
    a_pump_seq_load: assert property (cal_pump_valid && !w_pump |-> ##2
        pump_current == $past(cal_pump_result, 2))
        else $error("pump result load not seen");
    a_vco_seq_load: assert property (cal_vco_valid && !w_vco |-> ##2
        osc_current == $past(cal_vco_result, 2))
        else $error("vco result load not seen");
    a_wake_pump_reset: assert property ((wake_deep_sleep_a
        || wake_deep_sleep_b) |-> ##[3:6] ({pump_cal_config,
        pump_cal_stage_run, pump_current} == {2'h2, 1'b1, 4'h0}))
        else $error("pump register not reset after wake");
    a_read_upper_zero: assert property (take && !hwrite |=>
        hrdata[31:8] == 24'h0)
        else $error("unused read data bits not zero");
endmodule : fe_cal_regs_asserts

bind fe_cal_regs fe_cal_regs_asserts u_fe_cal_regs_asserts (.*);

// file: verif/fe_cal_regs_tb.sv
/* testbench: AHB-Lite master, integer register model, sequencer and wake
   stimulus for the register set. assumes a zero-wait slave is fine. */
module fe_cal_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    wire logic hready = hreadyout;
    logic wake_deep_sleep_a = 1'b0;
    logic wake_deep_sleep_b = 1'b0;
    logic cal_pump_valid = 1'b0;
    logic [3:0] cal_pump_result = 4'h0;
    logic cal_vco_valid = 1'b0;
    logic [4:0] cal_vco_result = 5'h0;
    logic [1:0] low_noise_amp_bias, amp_to_mixer_bias, rx_lo_buffer_bias;
    logic [1:0] mixer_bias, tx_lo_buffer_bias, pump_cal_config;
    logic [2:0] tx_reserved;
    logic pump_cal_stage_run, osc_core_select;
    logic [3:0] pump_current;
    logic [4:0] osc_current;
    logic [31:0] rd;
    logic [31:0] adr[4];
    int mdl[4];
    int msk[4] = '{32'hFF, 32'h37, 32'hFF, 32'h3F};
    int fails = 0;
    int n_tests = 0;
    int i, d, sv2, sv3;

    always #12.5 hclk = ~hclk;
    fe_cal_regs dut (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    task automatic xfer(input logic [31:0] a, input logic w, input int wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= fe_cal_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check(hresp, fe_cal_pkg::HRESP_OKAY);
    endtask : xfer

    task automatic wr(input int r, input int wd);
        xfer(adr[r], 1'b1, wd);
        mdl[r] = wd & msk[r];
    endtask : wr

    task automatic rd_chk(input int r);
        xfer(adr[r], 1'b0, 0);
        check(rd, mdl[r]);
    endtask : rd_chk

    // outputs settle one cycle after the field
    task automatic check_outs();
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        check({low_noise_amp_bias, amp_to_mixer_bias, rx_lo_buffer_bias,
            mixer_bias}, mdl[0]);
        check({tx_lo_buffer_bias, 1'b0, tx_reserved}, mdl[1]);
        check({pump_cal_config, 2'h0, pump_current}, mdl[2] & 32'hCF);
        check(pump_cal_stage_run, (mdl[2] & 32'h30) != 0);
        check({osc_core_select, osc_current}, mdl[3]);
        @(posedge hclk);
    endtask : check_outs

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h4186));
        adr = '{{14'h0, fe_cal_pkg::ADDR_RX_TRIM},
            {14'h0, fe_cal_pkg::ADDR_TX_TRIM},
            {14'h0, fe_cal_pkg::ADDR_CAL_PUMP},
            {14'h0, fe_cal_pkg::ADDR_CAL_VCO}};
        mdl = '{32'h56, 32'h10, 32'hA0, 32'h0A};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (i = 0; i < 4; i++) rd_chk(i);
        check_outs();
        repeat (24) begin
            i = $urandom_range(3);
            d = $urandom;
            // software keeps reserved bits at zero
            if (i == 1) d = d & 32'hFFFFFFF8;
            wr(i, d);
            rd_chk(i);
            check_outs();
        end
        wr(2, 32'h8F); // config left at 10 for calibration
        check_outs();
        xfer(32'h00037C78, 1'b1, 32'hFF);
        xfer(32'h00037C78, 1'b0, 0);
        check(rd, 32'h0);
        for (i = 0; i < 2; i++) begin
            @(posedge hclk);
            // second pass differs from the saved results, so restore shows
            cal_pump_result <= 4'(sv3) ^ 4'($urandom_range(15, 1));
            cal_vco_result <= 5'(sv2) ^ 5'($urandom_range(31, 1));
            cal_pump_valid <= 1'b1;
            cal_vco_valid <= 1'b1;
            @(posedge hclk);
            cal_pump_valid <= 1'b0;
            cal_vco_valid <= 1'b0;
            mdl[2] = (mdl[2] & 32'hF0) | cal_pump_result;
            mdl[3] = (mdl[3] & 32'h20) | cal_vco_result;
            rd_chk(2);
            rd_chk(3);
            if (i == 0) sv2 = mdl[3];
            if (i == 0) sv3 = mdl[2];
        end
        wr(2, sv3);
        wr(3, sv2);
        rd_chk(2);
        check_outs();
        // both deep-sleep wakes reset the pump register only
        for (i = 0; i < 2; i++) begin
            wr(2, 32'h5B);
            wake_deep_sleep_a <= (i == 0);
            wake_deep_sleep_b <= (i == 1);
            @(posedge hclk);
            wake_deep_sleep_a <= 1'b0;
            wake_deep_sleep_b <= 1'b0;
            repeat (6) @(posedge hclk);
            mdl[2] = 32'hA0;
            rd_chk(2);
            rd_chk(3);
            check_outs();
        end
        finish_test();
    end
endmodule : fe_cal_regs_tb
